// file: ccw_pkg.sv
// Constants for the clock configuration byte decoder.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package ccw_pkg;
    // Register byte offsets
    localparam logic [3:0] CCW_OFS_CFG = 4'h0;
    localparam logic [3:0] CCW_OFS_MODE = 4'h4;
    localparam logic [3:0] CCW_OFS_SWITCH = 4'h8;
    localparam logic [3:0] CCW_OFS_PIN = 4'hC;
    // Configuration byte fields
    localparam int CCW_BIT_FAIL_SAFE = 5;
    localparam int CCW_BIT_SWITCH_WE = 3;
    localparam int CCW_BIT_PRIO_ONE_SHOT = 1;
    localparam int CCW_BIT_CLK_OUT_EN = 0;
    localparam logic [7:0] CCW_CFG_IMPL_MASK = 8'h2B;
    localparam logic [7:0] CCW_CFG_RESET = 8'hFF;
    // External oscillator mode field and encodings
    localparam logic [2:0] CCW_MODE_RESET = 3'h7;
    localparam logic [2:0] CCW_MODE_EXT_HIGH = 3'h7;
    localparam logic [2:0] CCW_MODE_EXT_MED = 3'h6;
    localparam logic [2:0] CCW_MODE_EXT_LOW = 3'h5;
    localparam logic [2:0] CCW_MODE_OFF = 3'h4;
    // Clock switch register fields
    localparam int CCW_DIV_LSB = 0;
    localparam int CCW_SRC_LSB = 4;
    localparam logic [2:0] CCW_SRC_RESET = 3'h0;
    localparam logic [3:0] CCW_DIV_RESET = 4'h0;
    // Pin register fields
    localparam int CCW_PIN_DATA = 0;
    localparam int CCW_PIN_DIR = 1;
    localparam int CCW_PIN_CLK_ACTIVE = 4;
    localparam int CCW_PIN_OSC_OWNS = 5;
    // Clock output divide ratio
    localparam int CCW_CLK_OUT_DIV = 4;
    // Bus answers
    localparam logic [1:0] CCW_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCW_RESP_SLVERR = 2'h2;
endpackage : ccw_pkg

// file: ccw_clk_div.sv
// Divides the system clock by a fixed ratio for the clock output pin.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module ccw_clk_div
    import ccw_pkg::*;
#(
    parameter int DIV = CCW_CLK_OUT_DIV
) (
    input wire logic ref_clk_in, // System clock
    input wire logic sys_rst_in, // Async reset, active high
    output logic div_clk_out // Divided clock, 50 percent duty
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic div_reg;
    logic div_next;

    // Count half periods and toggle the output at each end
    always_comb begin
        cnt_next = cnt_reg + CW'(1);
        div_next = div_reg;
        if (cnt_reg == HALF) begin
            cnt_next = '0;
            div_next = ~div_reg;
        end
    end

    // State registers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_reg <= '0;
            div_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            div_reg <= div_next;
        end
    end

    assign div_clk_out = div_reg;
endmodule : ccw_clk_div

// file: ccw_decode.sv
// Clock configuration byte decoder with an AXI4-Lite register slave.
// Assumes one system clock; the bus master keeps valid and payload until ready.
//
// Operation
// RL1 - Fail-safe monitor enable bit set turns the fail-safe clock monitor on.
// RL2 - Switch write enable gates software writes to clock source and divider fields.
// RL3 - External clock or disabled mode: clock out bit one gives plain I/O.
// RL4 - Other oscillator modes ignore clock out bit; oscillator owns the pin.
// RL5 - Unimplemented config bits read one; all bits are one when unprogrammed.
// RL6 - Active clock output runs at one quarter of the system clock.
// RL7 - External clock or disabled mode: clock out bit zero drives divided clock.
`timescale 1ns/1ps
module ccw_decode
    import ccw_pkg::*;
(
    input wire logic ref_clk_in, // System clock, 100 MHz
    input wire logic sys_rst_in, // Async reset, active high
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic fail_safe_monitor_out, // Fail-safe clock monitor enable
    output logic priority_lock_one_shot_out, // Priority lock one-shot setting
    output logic [2:0] new_osc_source_select_out, // Requested clock source
    output logic [3:0] new_clock_divider_out, // Requested clock divider
    output logic osc_pin_data_out, // Output pin value
    output logic osc_pin_oe_out, // Output pin enable, high drives
    output logic osc_owns_pin_out // Oscillator circuit controls pin
);
    logic [7:0] cfg_reg, cfg_next;
    logic [2:0] mode_reg, mode_next;
    logic [2:0] src_reg, src_next;
    logic [3:0] div_reg, div_next;
    logic gpio_data_reg, gpio_data_next;
    logic gpio_dir_reg, gpio_dir_next;
    logic aw_held_reg, aw_held_next;
    logic [3:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic fsm_reg, prio_reg, owns_reg, pin_data_reg, pin_oe_reg;
    logic fsm_next, prio_next, owns_next, pin_data_next, pin_oe_next;
    logic quarter_clk;
    logic ext_or_off;
    logic clk_active;
    logic do_write;

    // Fosc/4 source for the clock output function
    ccw_clk_div #(
        .DIV(CCW_CLK_OUT_DIV)
    ) u_div (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .div_clk_out(quarter_clk)
    ); // see RL6

    // Pin mode decode from the oscillator mode and clock out bit
    always_comb begin
        ext_or_off = (mode_reg == CCW_MODE_EXT_HIGH) || (mode_reg == CCW_MODE_EXT_MED)
            || (mode_reg == CCW_MODE_EXT_LOW) || (mode_reg == CCW_MODE_OFF);
        clk_active = ext_or_off && !cfg_reg[CCW_BIT_CLK_OUT_EN]; // see RL7
    end

    // Write channel handshake: address and data taken in either order
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        do_write = 1'b0;
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_held_reg && w_held_reg && !bvalid_reg) begin
            do_write = 1'b1;
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (aw_addr_reg[1:0] == 2'b00) ? CCW_RESP_OKAY : CCW_RESP_SLVERR;
        end
        awready_next = !aw_held_next && !bvalid_next && !do_write;
        wready_next = !w_held_next && !bvalid_next && !do_write;
    end

    // Register file writes, low byte lane only
    always_comb begin
        cfg_next = cfg_reg;
        mode_next = mode_reg;
        src_next = src_reg;
        div_next = div_reg;
        gpio_data_next = gpio_data_reg;
        gpio_dir_next = gpio_dir_reg;
        if (do_write && w_strb_reg[0] && aw_addr_reg[1:0] == 2'b00) begin
            case (aw_addr_reg)
                CCW_OFS_CFG: begin
                    cfg_next = (w_data_reg[7:0] & CCW_CFG_IMPL_MASK)
                        | ~CCW_CFG_IMPL_MASK; // see RL5
                end
                CCW_OFS_MODE: begin
                    mode_next = w_data_reg[2:0];
                end
                CCW_OFS_SWITCH: begin
                    if (cfg_reg[CCW_BIT_SWITCH_WE]) begin // see RL2
                        src_next = w_data_reg[CCW_SRC_LSB +: 3];
                        div_next = w_data_reg[CCW_DIV_LSB +: 4];
                    end
                end
                CCW_OFS_PIN: begin
                    gpio_data_next = w_data_reg[CCW_PIN_DATA];
                    gpio_dir_next = w_data_reg[CCW_PIN_DIR];
                end
                default: begin
                    cfg_next = cfg_reg;
                end
            endcase
        end
    end

    // Read channel: one read at a time, data held until taken
    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = CCW_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            case (s_axi_araddr)
                CCW_OFS_CFG: rdata_next[7:0] = cfg_reg; // see RL5
                CCW_OFS_MODE: rdata_next[2:0] = mode_reg;
                CCW_OFS_SWITCH: begin
                    rdata_next[CCW_SRC_LSB +: 3] = src_reg;
                    rdata_next[CCW_DIV_LSB +: 4] = div_reg;
                end
                CCW_OFS_PIN: begin
                    rdata_next[CCW_PIN_DATA] = gpio_data_reg;
                    rdata_next[CCW_PIN_DIR] = gpio_dir_reg;
                    rdata_next[CCW_PIN_CLK_ACTIVE] = clk_active;
                    rdata_next[CCW_PIN_OSC_OWNS] = !ext_or_off;
                end
                default: rresp_next = CCW_RESP_SLVERR;
            endcase
        end
    end

    // Static decode of the configuration byte onto control outputs
    always_comb begin
        fsm_next = cfg_reg[CCW_BIT_FAIL_SAFE]; // see RL1
        prio_next = cfg_reg[CCW_BIT_PRIO_ONE_SHOT];
        owns_next = !ext_or_off; // see RL4
        if (!ext_or_off) begin
            pin_data_next = 1'b0; // see RL4
            pin_oe_next = 1'b0;
        end else if (clk_active) begin
            pin_data_next = quarter_clk; // see RL6
            pin_oe_next = 1'b1;
        end else begin
            pin_data_next = gpio_data_reg; // see RL3
            pin_oe_next = gpio_dir_reg;
        end
    end

    // All state registers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_reg <= CCW_CFG_RESET; // see RL5
            mode_reg <= CCW_MODE_RESET;
            src_reg <= CCW_SRC_RESET;
            div_reg <= CCW_DIV_RESET;
            gpio_data_reg <= 1'b0;
            gpio_dir_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= CCW_RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= CCW_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            fsm_reg <= 1'b1;
            prio_reg <= 1'b1;
            owns_reg <= 1'b0;
            pin_data_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            mode_reg <= mode_next;
            src_reg <= src_next;
            div_reg <= div_next;
            gpio_data_reg <= gpio_data_next;
            gpio_dir_reg <= gpio_dir_next;
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            fsm_reg <= fsm_next;
            prio_reg <= prio_next;
            owns_reg <= owns_next;
            pin_data_reg <= pin_data_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign fail_safe_monitor_out = fsm_reg;
    assign priority_lock_one_shot_out = prio_reg;
    assign new_osc_source_select_out = src_reg;
    assign new_clock_divider_out = div_reg;
    assign osc_pin_data_out = pin_data_reg;
    assign osc_pin_oe_out = pin_oe_reg;
    assign osc_owns_pin_out = owns_reg;
endmodule : ccw_decode

// file: ccw_decode_chk.sv
// Port checks for the clock configuration byte decoder.
// Assumes one clock, async active-high reset; attached to the decoder by bind.
`timescale 1ns/1ps
module ccw_decode_chk
    import ccw_pkg::*;
(
    input wire logic ref_clk_in, // System clock
    input wire logic sys_rst_in, // Reset
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic fail_safe_monitor_out, // Monitor enable
    input wire logic [2:0] new_osc_source_select_out, // Clock source
    input wire logic [3:0] new_clock_divider_out, // Clock divider
    input wire logic osc_pin_data_out, // Pin value
    input wire logic osc_pin_oe_out, // Pin drive enable
    input wire logic osc_owns_pin_out // Oscillator owns pin
);
    logic [3:0] rd_addr_reg;
    logic [3:0] rd_addr_next;
    logic rd_new;

    // Remember the address of the read in flight
    always_comb begin
        rd_addr_next = rd_addr_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_next = s_axi_araddr;
        end
    end
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_addr_reg <= 4'h0;
        end else begin
            rd_addr_reg <= rd_addr_next;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // Pin and bus handshake checks; read answers compared against the live outputs on their first cycle
    property p_pin_quiet;
        osc_owns_pin_out |-> !osc_pin_oe_out && !osc_pin_data_out;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("pin driven while oscillator owns it");
    property p_fsm_match;
        $rose(s_axi_rvalid) && rd_addr_reg == CCW_OFS_CFG
            |-> fail_safe_monitor_out == s_axi_rdata[CCW_BIT_FAIL_SAFE];
    endproperty
    a_fsm_match: assert property (p_fsm_match)
        else $error("monitor enable differs from config bit");
    property p_unimpl_ones;
        $rose(s_axi_rvalid) && rd_addr_reg == CCW_OFS_CFG
            |-> (s_axi_rdata[7:0] | CCW_CFG_IMPL_MASK) == 8'hFF;
    endproperty
    a_unimpl_ones: assert property (p_unimpl_ones)
        else $error("unimplemented config bit reads zero");
    property p_switch_match;
        $rose(s_axi_rvalid) && rd_addr_reg == CCW_OFS_SWITCH |-> s_axi_rdata[6:0]
            == {new_osc_source_select_out, new_clock_divider_out};
    endproperty
    a_switch_match: assert property (p_switch_match)
        else $error("switch outputs differ from register");
    property p_clk_drives;
        $rose(s_axi_rvalid) && rd_addr_reg == CCW_OFS_PIN && s_axi_rdata[CCW_PIN_CLK_ACTIVE]
            |-> osc_pin_oe_out && !osc_owns_pin_out;
    endproperty
    a_clk_drives: assert property (p_clk_drives)
        else $error("active clock output not driven");
    property p_owner_reads;
        $rose(s_axi_rvalid) && rd_addr_reg == CCW_OFS_PIN
            |-> s_axi_rdata[CCW_PIN_OSC_OWNS] == osc_owns_pin_out;
    endproperty
    a_owner_reads: assert property (p_owner_reads)
        else $error("owner flag differs from output");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer late");
    property p_write_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write answer late");
    property p_resp_holds;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_resp_holds: assert property (p_resp_holds)
        else $error("write response dropped");

    // Main scenarios reached
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_clk: cover property ($rose(s_axi_rvalid) && s_axi_rdata[CCW_PIN_CLK_ACTIVE]);
    c_owned: cover property (osc_owns_pin_out);
endmodule : ccw_decode_chk

bind ccw_decode ccw_decode_chk chk_u (.ref_clk_in, .sys_rst_in, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .fail_safe_monitor_out, .new_osc_source_select_out,
    .new_clock_divider_out, .osc_pin_data_out, .osc_pin_oe_out, .osc_owns_pin_out);

// file: clock_config_word_decode_tb_top.sv
// Self-checking bench for the clock configuration byte decoder.
// Assumes the decoder's register map and bus timing; the bench drives every input port.
`timescale 1ns/1ps
module clock_config_word_decode_tb_top
    import ccw_pkg::*;
;
    logic ref_clk_in, sys_rst_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, fail_safe_monitor_out, priority_lock_one_shot_out;
    logic osc_pin_data_out, osc_pin_oe_out, osc_owns_pin_out, ext, act;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, new_clock_divider_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [2:0] new_osc_source_select_out;
    // Mode table: bit3 says the mode is external clock or disabled
    logic [3:0] mode_tab [8] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'h3, 4'h2, 4'h1, 4'h0};
    int miscompares = 0;
    int n_compared = 0;

    ccw_decode dut_u (.ref_clk_in, .sys_rst_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .fail_safe_monitor_out, .priority_lock_one_shot_out, .new_osc_source_select_out,
        .new_clock_divider_out, .osc_pin_data_out, .osc_pin_oe_out, .osc_owns_pin_out);

    // System clock, 100 MHz
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // Bus write; the response is stalled one cycle before bready rises
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
            @(posedge ref_clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) begin
            chk("write timeout", 0, 1);
            finish_test();
        end
    endtask : axi_wr

    // Bus read, then masked compare of data and response
    task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] er);
        int n;
        @(posedge ref_clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
            @(posedge ref_clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (n == 50) begin
            chk("read timeout", 0, 1);
            finish_test();
        end
        chk("read resp", 32'(er), 32'(s_axi_rresp));
        chk("read data", e, rd & m);
    endtask : rdchk

    // Eight samples of the pin: clock gives two high, two low; otherwise the idle level
    task automatic pin_watch(input logic on, input logic [7:0] idle);
        logic [7:0] s;
        logic ok;
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk_in);
            s[k] = osc_pin_data_out;
        end
        ok = on ? (s === 8'h33 || s === 8'h66 || s === 8'hCC || s === 8'h99) : s === idle;
        chk("pin wave", 1, 32'(ok));
    endtask : pin_watch

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        sys_rst_in = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        // Unprogrammed state
        rdchk(CCW_OFS_CFG, 32'h0000_00FF, 32'h0000_00FF, CCW_RESP_OKAY);
        chk("monitor", 1, fail_safe_monitor_out);
        chk("owner oe", 0, {osc_owns_pin_out, osc_pin_oe_out});
        chk("prio", 1, priority_lock_one_shot_out);
        // General I/O drives a high level so the plain pin path shows up
        axi_wr(CCW_OFS_PIN, 32'h0000_0003);
        // Every mode with clock out enable low and high
        for (int i = 0; i < 8; i++) begin
            for (int c = 0; c < 2; c++) begin
                ext = mode_tab[i][3];
                act = ext && !c[0];
                axi_wr(CCW_OFS_CFG, {26'h0, i[0], 3'b010, i[1], c[0]});
                axi_wr(CCW_OFS_MODE, {29'h0, mode_tab[i][2:0]});
                rdchk(CCW_OFS_CFG, 32'hFFFF_FFFF, {24'h0, 2'b11, i[0], 3'b111, i[1], c[0]},
                      CCW_RESP_OKAY);
                rdchk(CCW_OFS_PIN, 32'h0000_0030, {26'h0, !ext, act, 4'h0},
                      CCW_RESP_OKAY);
                chk("monitor", 32'(i[0]), fail_safe_monitor_out);
                chk("prio", 32'(i[1]), priority_lock_one_shot_out);
                chk("owner", 32'(!ext), osc_owns_pin_out);
                chk("pin oe", 32'(ext), osc_pin_oe_out);
                pin_watch(act, {8{ext}});
            end
        end
        // Switch fields locked, then open, at their widest values
        axi_wr(CCW_OFS_CFG, 32'h0000_0000);
        axi_wr(CCW_OFS_SWITCH, 32'h0000_007F);
        chk("locked resp", CCW_RESP_OKAY, rs);
        rdchk(CCW_OFS_SWITCH, 32'h0000_007F, 32'h0000_0000, CCW_RESP_OKAY);
        axi_wr(CCW_OFS_CFG, 32'h0000_0008);
        axi_wr(CCW_OFS_SWITCH, 32'h0000_007F);
        rdchk(CCW_OFS_SWITCH, 32'h0000_007F, 32'h0000_007F, CCW_RESP_OKAY);
        chk("switch out", 32'h0000_007F, {new_osc_source_select_out, new_clock_divider_out});
        // Misaligned write and unmapped read are refused
        axi_wr(4'h2, 32'h0000_0000);
        chk("bad write resp", CCW_RESP_SLVERR, rs);
        rdchk(4'h6, 32'hFFFF_FFFF, 32'h0000_0000, CCW_RESP_SLVERR);
        // A write with no byte lane enabled leaves the byte alone
        s_axi_wstrb <= 4'h0;
        axi_wr(CCW_OFS_CFG, 32'h0000_0000);
        s_axi_wstrb <= 4'hF;
        chk("no lane resp", CCW_RESP_OKAY, rs);
        rdchk(CCW_OFS_CFG, 32'hFFFF_FFFF, 32'h0000_00DC, CCW_RESP_OKAY);
        // Reset in mid-run restores the unprogrammed byte
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rdchk(CCW_OFS_CFG, 32'hFFFF_FFFF, 32'h0000_00FF, CCW_RESP_OKAY);
        rdchk(CCW_OFS_SWITCH, 32'h0000_007F, 32'h0000_0000, CCW_RESP_OKAY);
        finish_test();
    end
endmodule : clock_config_word_decode_tb_top
